//--- hw/dom_guard.sv
// Guard that never holds the transmit line dominant beyond a limit
`timescale 1ns/100ps
module dom_guard
    import xcvr_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    dom_guard_if.guard g
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic blocked;
        logic tx_out;
        logic cut;
    } guard_s;

    guard_s st;
    guard_s next_st;

    // Count dominant time, force recessive when the limit is reached
    always_comb begin
        next_st = st;
        next_st.cut = 1'b0;
        if (!g.enable || g.tx_req) begin
            next_st.count = '0;
            next_st.blocked = 1'b0;          // Recessive request releases
            next_st.tx_out = 1'b1;
        end else if (st.blocked) begin
            next_st.tx_out = 1'b1;           // Wait for a recessive request
        end else if (st.count >= g.limit) begin
            next_st.blocked = 1'b1;
            next_st.tx_out = 1'b1;
            next_st.cut = 1'b1;
        end else begin
            next_st.count = st.count + 1'b1;
            next_st.tx_out = 1'b0;           // Low is dominant
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '{count: '0, blocked: 1'b0, tx_out: 1'b1, cut: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign g.tx_out = st.tx_out;
    assign g.cut = st.cut;

endmodule

//--- hw/dom_guard_if.sv
// Interface between the controller core and the dominant-hold guard
`timescale 1ns/100ps
interface dom_guard_if;
    logic tx_req;      // Requested transmit level, 1 = recessive
    logic enable;      // Guard active only in normal mode
    logic [23:0] limit;
    logic tx_out;      // Level allowed onto the transmit line
    logic cut;         // One-cycle pulse when a hold was cut

    modport core (output tx_req, output enable, output limit,
                  input tx_out, input cut);
    modport guard (input tx_req, input enable, input limit,
                   output tx_out, output cut);
endinterface

//--- hw/xcvr_ctrl.sv
// Host-side controller driving a CAN FD transceiver's mode and data pins
// Software sets the mode and transmit level through its own registers;
// a guard cuts any dominant hold at the count in REG_TX_LIMIT, which resets
// to one cycle short of the transceiver's timeout, and receive-line
// events raise a maskable interrupt.
`timescale 1ns/100ps
module xcvr_ctrl
    import xcvr_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic tx_line,
    input wire logic rx_line,
    output logic standby_select,
    output logic shutdown_select
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mode;
        logic tx_level;
        logic auto_wake;
        logic [CNT_W-1:0] limit;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        logic [31:0] rdata;
        logic std_pin;
        logic shd_pin;
    } ctrl_s;

    ctrl_s st;
    ctrl_s next_st;
    dom_guard_if gi ();

    logic wr;
    logic rd;
    logic addr_ok;
    logic wake_seen;
    logic bus_fall;
    logic [IRQ_W-1:0] events;

    // ------------------------------------------------------------
    // Guard on the transmit line
    // ------------------------------------------------------------
    // At the reset limit, cutting the hold here, one cycle before the
    // transceiver's own timeout, keeps its driver from having to switch itself off
    dom_guard u_guard (
        .clk(clk),
        .resetn(resetn),
        .g(gi.guard)
    );

    // Guard follows the requested level only while in normal mode
    assign gi.tx_req = st.tx_level;
    assign gi.enable = (st.mode == MODE_NORMAL);
    assign gi.limit = st.limit;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Zero wait states: every access phase lasts one cycle. Read data
    // is captured at the setup edge so that it stands on prdata for
    // the whole access phase.
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign addr_ok = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                     (paddr == REG_IRQ_STAT) || (paddr == REG_IRQ_MASK) ||
                     (paddr == REG_TX_LIMIT);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // Receive-line events; low on the receive line is dominant
    // The edge detector resets to the recessive level, so leaving reset
    // shows a falling edge only if the receive line is already dominant
    assign bus_fall = st.rx_prev && !st.rx_s2;
    // Falling receive line in standby mode is a wake indication
    assign wake_seen = bus_fall && (st.mode == MODE_STANDBY);
    // Bus edges count only in normal mode, where rx mirrors the bus
    assign events = {bus_fall && (st.mode == MODE_NORMAL), gi.cut, wake_seen};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Two-stage synchroniser on the receive pin
        next_st.rx_s1 = rx_line;
        next_st.rx_s2 = st.rx_s1;
        next_st.rx_prev = st.rx_s2;
        // Register writes
        if (wr) begin
            case (paddr)
                REG_CTRL: begin
                    // Mode, transmit level and auto wake form one word
                    next_st.mode = pwdata[CTRL_MODE_LSB +: 2];
                    next_st.tx_level = pwdata[CTRL_TX_BIT];
                    next_st.auto_wake = pwdata[CTRL_AUTO_WAKE];
                end
                REG_IRQ_STAT: begin
                    next_st.irq_stat = st.irq_stat & ~pwdata[IRQ_W-1:0];
                end
                REG_IRQ_MASK: begin
                    next_st.irq_mask = pwdata[IRQ_W-1:0];
                end
                REG_TX_LIMIT: begin
                    // Zero cuts every dominant request before the pin
                    next_st.limit = pwdata[CNT_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Invalid mode code falls back to standby
        // Standby is the safe choice, as it keeps the driver off
        if (next_st.mode == 2'b11) begin
            next_st.mode = MODE_STANDBY;
        end
        // Set wins over a clear in the same cycle
        // A W1C write racing an event must not lose the event
        next_st.irq_stat = next_st.irq_stat | events;
        // Return to normal after wake when enabled
        // Off after reset, so software decides when to leave standby
        if (wake_seen && st.auto_wake) begin
            next_st.mode = MODE_NORMAL;
        end
        // Pins driven every cycle; shutdown wins
        {next_st.shd_pin, next_st.std_pin} =
            mode_pins(next_st.mode);
        // Read data, captured in the setup cycle
        next_st.rdata = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                REG_CTRL: begin
                    next_st.rdata = {28'h000_0000, st.auto_wake,
                                     st.tx_level, st.mode};
                end
                REG_STATUS: begin
                    // Bit 3 shows the one-cycle cut pulse, mostly for polling
                    next_st.rdata = {28'h000_0000, gi.cut, st.rx_s2,
                                     gi.tx_out, st.mode == MODE_NORMAL};
                end
                REG_IRQ_STAT: begin
                    next_st.rdata = {29'h0000_0000, st.irq_stat};
                end
                REG_IRQ_MASK: begin
                    next_st.rdata = {29'h0000_0000, st.irq_mask};
                end
                REG_TX_LIMIT: begin
                    next_st.rdata = {8'h00, st.limit};
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset leaves standby selected and the transmit line recessive,
    // the same levels the transceiver's own pin bias would give
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st.mode <= CTRL_RESET[CTRL_MODE_LSB +: 2];
            st.tx_level <= CTRL_RESET[CTRL_TX_BIT];
            st.auto_wake <= CTRL_RESET[CTRL_AUTO_WAKE];
            st.limit <= CNT_W'(DOM_LIMIT_CYCLES - 1);
            st.irq_stat <= '0;
            st.irq_mask <= '0;
            st.rx_s1 <= 1'b1;
            st.rx_s2 <= 1'b1;
            st.rx_prev <= 1'b1;
            st.rdata <= 32'h0000_0000;
            st.std_pin <= 1'b1;
            st.shd_pin <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign prdata = st.rdata;
    // Level interrupt, high until software clears or masks the cause
    assign irq = |(st.irq_stat & st.irq_mask);
    assign tx_line = gi.tx_out;
    assign standby_select = st.std_pin;
    assign shutdown_select = st.shd_pin;

endmodule

//--- hw/xcvr_ctrl_pkg.sv
// Package with register map, fields and timing constants of the controller
package xcvr_ctrl_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses on APB)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_TX_LIMIT = 8'h10;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;      // 2-bit requested mode
    localparam int CTRL_TX_BIT = 2;        // Transmit level, 1 = recessive
    localparam int CTRL_AUTO_WAKE = 3;     // Return to normal on wake
    localparam logic [3:0] CTRL_RESET = 4'h5; // Standby, tx recessive

    // ------------------------------------------------------------
    // Interrupt bit positions
    // ------------------------------------------------------------
    localparam int IRQ_WAKE = 0;           // Wake indication seen
    localparam int IRQ_TX_CUT = 1;         // Dominant hold cut short
    localparam int IRQ_BUS_DOM = 2;        // Bus went dominant
    localparam int IRQ_W = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int DOM_TIMEOUT_US = 1200;  // Shortest device timeout
    localparam int MAX_DOM_BITS = 11;      // Longest legal dominant run
    // Dominant hold limit, equal to the device timeout in clock cycles
    localparam int DOM_LIMIT_CYCLES = (DOM_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
    localparam int CNT_W = 24;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_STANDBY = 2'b01,
        MODE_SHUTDOWN = 2'b10
    } mode_e;

    // Pin levels for a mode: {shutdown_select, standby_select}
    function automatic logic [1:0] mode_pins(input logic [1:0] m);
        case (m)
            MODE_NORMAL: mode_pins = 2'b00;
            MODE_SHUTDOWN: mode_pins = 2'b11;
            default: mode_pins = 2'b01;
        endcase
    endfunction

endpackage

//--- sim/test_xcvr_ctrl.sv
// Self-checking bench for the transceiver controller
`timescale 1ns/100ps
module test_xcvr_ctrl;
    import xcvr_ctrl_pkg::*;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, irq, tx_line, rx_line, stby, shut_sel;
    logic other_dom = 0, wake = 0;
    int fail_count = 0, cmp_count = 0, cycles = 0, seed = 32'he588;
    logic [31:0] exp_q[$];
    initial forever #5 clk = ~clk;
    xcvr_ctrl DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .tx_line(tx_line),
        .rx_line(rx_line), .standby_select(stby), .shutdown_select(shut_sel));
    xcvr_model #(.DOM_TIMEOUT(60)) partner (.clk(clk), .tx_line(tx_line),
        .standby_select(stby), .shutdown_select(shut_sel),
        .other_dom(other_dom), .wake(wake), .rx_line(rx_line));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One APB transfer, held until ready is seen
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        apb(0, a, 0);
    endtask
    // Read data watcher and hang limit
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
            check(prdata, exp_q.pop_front());
        cycles++;
        if (cycles > 20000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1;
        rd(REG_CTRL, 32'h0000_0005);
        rd(REG_STATUS, 32'h0000_0006);
        rd(REG_TX_LIMIT, 32'h0001_d4bf);
        rd(8'h14, 32'h0000_0000);
        apb(1, REG_TX_LIMIT, 32'h0000_0014);
        apb(1, REG_IRQ_MASK, 32'h0000_0007);
        apb(1, REG_CTRL, 32'h0000_0004);
        // Random traffic of other nodes seen on the receive line
        repeat (8) begin
            other_dom <= 1'($random(seed));
            repeat (4) @(posedge clk);
            rd(REG_STATUS, {29'h0000_0000, !other_dom, 2'b11});
        end
        other_dom <= 0;
        repeat (6) @(posedge clk);
        apb(1, REG_IRQ_STAT, 32'h0000_0007);
        apb(1, REG_CTRL, 32'h0000_0000);
        repeat (40) @(posedge clk);
        check(32'(tx_line), 32'h0000_0001);
        check(32'(irq), 32'h0000_0001);
        rd(REG_IRQ_STAT, 32'h0000_0006);
        apb(1, REG_IRQ_STAT, 32'h0000_0006);
        apb(1, REG_CTRL, 32'h0000_0005);
        repeat (4) @(posedge clk);
        check(32'(irq), 32'h0000_0000);
        wake <= 1;
        @(posedge clk);
        wake <= 0;
        repeat (6) @(posedge clk);
        check(32'(irq), 32'h0000_0001);
        apb(1, REG_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h0000_0000);
        rd(REG_IRQ_STAT, 32'h0000_0001);
        apb(1, REG_IRQ_STAT, 32'h0000_0001);
        apb(1, REG_CTRL, 32'h0000_0004);
        repeat (2) @(posedge clk);
        check(32'({shut_sel, stby}), 32'h0000_0000);
        apb(1, REG_CTRL, 32'h0000_0006);
        repeat (2) @(posedge clk);
        check(32'({shut_sel, stby}), 32'h0000_0003);
        apb(1, REG_CTRL, 32'h0000_0007);
        repeat (2) @(posedge clk);
        check(32'({shut_sel, stby}), 32'h0000_0001);
        stop_test();
    end
endmodule

//--- sim/xcvr_ctrl_properties.sv
// Port-level checker of the transceiver controller
`timescale 1ns/100ps
module xcvr_ctrl_props
    import xcvr_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tx_line,
    input wire logic standby_select,
    input wire logic shutdown_select
);
    int dom_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Length of the current dominant run on the transmit line
    always_ff @(posedge clk) begin
        dom_cnt <= (!resetn || tx_line) ? 0 : dom_cnt + 1;
    end
    sequence ctrl_wr(logic [1:0] m);
        psel && penable && pwrite && paddr == REG_CTRL && pwdata[1:0] == m;
    endsequence
    rst_vals_a: assert property (
        $rose(resetn) |-> tx_line && standby_select && !shutdown_select)
        else $error("pins not at rest after reset");
    apb_ready_a: assert property (psel && penable |-> pready)
        else $error("access without ready");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    unmapped_a: assert property (psel && penable && paddr == 8'h14 |-> pslverr)
        else $error("unmapped access not refused");
    to_normal_a: assert property (
        ctrl_wr(2'b00) |=> !standby_select && !shutdown_select)
        else $error("normal mode pins wrong");
    to_shut_a: assert property (
        ctrl_wr(2'b10) |=> shutdown_select && standby_select)
        else $error("shutdown pins wrong");
    to_stby_a: assert property (
        ctrl_wr(2'b11) |=> standby_select && !shutdown_select)
        else $error("code three not standby");
    quiet_tx_a: assert property (standby_select [*3] |-> tx_line)
        else $error("dominant outside normal mode");
    dom_bound_a: assert property (dom_cnt <= DOM_LIMIT_CYCLES)
        else $error("dominant held too long");
endmodule
bind xcvr_ctrl xcvr_ctrl_props u_props (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .tx_line(tx_line),
    .standby_select(standby_select), .shutdown_select(shutdown_select));

//--- sim/xcvr_model.sv
// Behavioural transceiver standing on the far side of the controller
`timescale 1ns/100ps
module xcvr_model #(parameter int DOM_TIMEOUT = 60) (
    input wire logic clk,
    input wire logic tx_line,
    input wire logic standby_select,
    input wire logic shutdown_select,
    input wire logic other_dom,
    input wire logic wake,
    output logic rx_line
);
    int dom_time = 0;
    logic fault = 1'b0;
    logic woke = 1'b0;
    logic normal, drv_on, bus_dom;
    // Mode decode, shutdown wins over standby
    assign normal = !shutdown_select &&
                    !standby_select;
    assign drv_on = normal && !fault;
    assign bus_dom = (drv_on && !tx_line) ||
                     (normal && other_dom);
    // Dominant timeout and wake latch
    always @(posedge clk) begin
        dom_time <= (normal && !tx_line) ? dom_time + 1 : 0;
        if (tx_line)
            fault <= 1'b0;
        else if (dom_time >= DOM_TIMEOUT)
            fault <= 1'b1;
        woke <= standby_select && !shutdown_select &&
                (woke || wake);
    end
    // Receive line: low is dominant, low on wake; supply always present
    assign rx_line = normal ? !bus_dom : !woke;
endmodule
